// >>> src/sfr_defs.vh
// Constants for the serial flash read engine: opcodes, phase lengths, register map
`ifndef SFR_DEFS_VH
`define SFR_DEFS_VH

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define SFR_OP_READ        8'h03
`define SFR_OP_FAST        8'h0B
`define SFR_OP_DUAL_OUT    8'h3B
`define SFR_OP_QUAD_OUT    8'h6B
`define SFR_OP_DUAL_IO     8'hBB
`define SFR_OP_QUAD_IO     8'hEB
`define SFR_OP_QUAD_WORD   8'hE7
`define SFR_OP_SET_WRAP    8'h77
`define SFR_OP_MODE_RST    8'hFF

// ----------------------------------------------------------------------------
// Phase lengths in serial clocks, address length in bits, and the repeat skip code
// ----------------------------------------------------------------------------
`define SFR_CMD_CLKS       5'h08
`define SFR_ADDR_BITS      5'h18
`define SFR_WRAP_CLKS      5'h08
`define SFR_MODE_CLKS_X2   5'h04
`define SFR_MODE_CLKS_X4   5'h02
`define SFR_DUMMY_FAST     5'h08
`define SFR_DUMMY_QUAD     5'h04
`define SFR_DUMMY_WORD     5'h02
`define SFR_SKIP_CODE      2'h2

// ----------------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------------
`define SFR_REG_CTRL       8'h00
`define SFR_REG_STAT       8'h04
`define SFR_REG_ADDR       8'h08
`define SFR_CTRL_QPE_BIT   9
`define SFR_CTRL_RST       1'h0
`define SFR_WRAP_RST       3'h7
`define SFR_WRAP_DIS_BIT   0

`endif

// >>> src/sfr_read_engine.v
// Serial flash read engine: SPI read command decoder with Wishbone control registers
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "sfr_defs.vh"

// Overview of operation
// RULE_01 - Opcode 03H takes 24 address bits, all sampled on rising serial clock.
// RULE_02 - Plain read shifts data on IO1 at falling edges, no dummy clocks.
// RULE_03 - Address increments after each byte; stream runs until select rises.
// RULE_04 - Reads arriving while busy are ignored and leave the busy cycle alone.
// RULE_05 - Opcode 0BH: address, one dummy byte, then single-line data.
// RULE_06 - Opcode 3BH: serial address, dummy byte, data two bits per clock.
// RULE_07 - Opcode 3BH sibling 6BH: serial address, dummy byte, four-bit data.
// RULE_08 - Opcode BBH: address and mode byte two bits per clock, dual data.
// RULE_09 - Dual I/O skip bits 10 make next transaction start at the address.
// RULE_10 - Skip bits other than 10 leave repeat mode; opcode needed again.
// RULE_11 - Mode reset command clears the repeat mode before other commands.
// RULE_12 - Opcode EBH: quad address, mode byte, four dummy clocks, quad data.
// RULE_13 - Four-line I/O reads are honoured only with quad path enable set.
// RULE_14 - EBH with skip bits 10 repeats without opcode after select toggles.
// RULE_15 - Wrap confines data to an aligned 8-64 byte section of a page.
// RULE_16 - Command 77H loads the wrap setting used by later quad I/O reads.
// RULE_17 - Wrap setting: bit four disables wrap, bits six-five give length.
// RULE_18 - Opcode E7H expects an even address and two dummy clocks.
// RULE_19 - E7H with skip bits 10 repeats without opcode after select toggles.
// RULE_20 - 77H carries 24 dummy bits then wrap byte; wrap reset is disabled.
// RULE_21 - Quad input nibbles carry IO3 as highest bit, from address bit 23.
// RULE_22 - Dual output puts odd bits on IO1, even bits on IO0, MSBs first.
// RULE_23 - All fields MSB first; select high aborts and returns to opcode wait.
// RULE_24 - First data bit follows the last address, mode or dummy clock.
module sfr_read_engine (
  input  wire        clk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        spi_sclk,
  input  wire        spi_cs_n,
  input  wire [3:0]  spi_io_in,
  output wire [3:0]  spi_io_out,
  output wire [3:0]  spi_io_oe,
  input  wire        array_busy,
  output wire [23:0] mem_addr,
  input  wire [7:0]  mem_data
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_CMD   = 7'h02;
  localparam [6:0] ST_ADDR  = 7'h04;
  localparam [6:0] ST_MODE  = 7'h08;
  localparam [6:0] ST_DUMMY = 7'h10;
  localparam [6:0] ST_DATA  = 7'h20;
  localparam [6:0] ST_SKIP  = 7'h40;

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Next address, wrapping inside an aligned section when enabled
  function [23:0] next_addr;
    input [23:0] a;
    input        wrap_on;
    input [1:0]  len;
    reg   [23:0] m;
    reg   [23:0] inc;
    begin
      m   = {16'h0000, (8'h08 << len) - 8'h01};
      inc = a + 24'h000001;
      next_addr = wrap_on ? ((a & ~m) | (inc & m)) : inc;
    end
  endfunction

  // Place the top bits of a byte onto the data lanes
  function [3:0] lane_out;
    input [7:0] b;
    input [2:0] w;
    begin
      case (w)
        3'h4:    lane_out = b[7:4];
        3'h2:    lane_out = {2'h0, b[7], b[6]};
        default: lane_out = {2'h0, b[7], 1'b0};
      endcase
    end
  endfunction

  // Shift a byte left by the lane width
  function [7:0] lane_shl;
    input [7:0] b;
    input [2:0] w;
    begin
      case (w)
        3'h4:    lane_shl = {b[3:0], 4'h0};
        3'h2:    lane_shl = {b[5:0], 2'h0};
        default: lane_shl = {b[6:0], 1'b0};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [2:0]  sclk_r;
  reg  [1:0]  cs_r;
  reg  [3:0]  io_m_r;
  reg  [3:0]  io_s_r;
  reg  [6:0]  st_r;
  reg  [4:0]  cnt_r;
  reg  [31:0] sh_r;
  reg  [7:0]  op_r;
  reg  [7:0]  rep_op_r;
  reg         skip_r;
  reg  [2:0]  ilw_r;
  reg  [2:0]  dlw_r;
  reg  [4:0]  mclk_r;
  reg  [4:0]  dclk_r;
  reg         wrap_use_r;
  reg  [2:0]  wrap_r;
  reg  [23:0] addr_r;
  reg  [7:0]  osh_r;
  reg  [2:0]  bcnt_r;
  reg  [3:0]  io_out_r;
  reg  [3:0]  io_oe_r;
  reg         qpe_r;
  reg         ack_r;
  reg  [31:0] dat_r;

  wire        sclk_rise = sclk_r[1] & ~sclk_r[2];
  wire        sclk_fall = ~sclk_r[1] & sclk_r[2];
  wire        cs_high   = cs_r[1];
  wire        last_clk  = (cnt_r == 5'h01);
  wire [31:0] sh_nxt;
  wire [7:0]  cmd_nxt   = {sh_r[6:0], io_s_r[0]};

  // Input shifter by lane width, nibble MSB on IO3 [RULE_21]
  assign sh_nxt = (ilw_r == 3'h4) ? {sh_r[27:0], io_s_r} :
                  (ilw_r == 3'h2) ? {sh_r[29:0], io_s_r[1:0]} :
                                    {sh_r[30:0], io_s_r[0]};

  assign spi_io_out = io_out_r;
  assign spi_io_oe  = io_oe_r;
  assign mem_addr   = addr_r;
  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = dat_r;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Two flops before use; a third sclk stage only feeds edge detection
  always @(posedge clk) begin
    if (rst) begin
      sclk_r <= 3'h0;
      cs_r   <= 2'h3;
      io_m_r <= 4'h0;
      io_s_r <= 4'h0;
    end else begin
      sclk_r <= {sclk_r[1:0], spi_sclk};
      cs_r   <= {cs_r[0], spi_cs_n};
      io_m_r <= spi_io_in;
      io_s_r <= io_m_r;
    end
  end

  // --------------------------------------------------------------------------
  // Read setup per opcode
  // --------------------------------------------------------------------------
  // Loads lane widths and phase lengths; address phase follows
  task start_read;
    input [7:0] op;
    begin
      op_r       <= op;
      st_r       <= ST_ADDR;
      mclk_r     <= 5'h00;
      dclk_r     <= 5'h00;
      ilw_r      <= 3'h1;
      dlw_r      <= 3'h1;
      wrap_use_r <= 1'b0;
      cnt_r      <= `SFR_ADDR_BITS;                      // [RULE_01]
      case (op)
        `SFR_OP_FAST:     dclk_r <= `SFR_DUMMY_FAST;     // [RULE_05]
        `SFR_OP_DUAL_OUT: begin
          dclk_r <= `SFR_DUMMY_FAST;                     // [RULE_06]
          dlw_r  <= 3'h2;
        end
        `SFR_OP_QUAD_OUT: begin
          dclk_r <= `SFR_DUMMY_FAST;                     // [RULE_07]
          dlw_r  <= 3'h4;
        end
        `SFR_OP_DUAL_IO: begin
          ilw_r  <= 3'h2;                                // [RULE_08]
          dlw_r  <= 3'h2;
          mclk_r <= `SFR_MODE_CLKS_X2;
          cnt_r  <= `SFR_ADDR_BITS >> 1;
        end
        `SFR_OP_QUAD_IO, `SFR_OP_QUAD_WORD: begin
          ilw_r      <= 3'h4;                            // [RULE_12]
          dlw_r      <= 3'h4;
          mclk_r     <= `SFR_MODE_CLKS_X4;
          cnt_r      <= `SFR_ADDR_BITS >> 2;
          wrap_use_r <= 1'b1;                            // [RULE_16]
          dclk_r     <= (op == `SFR_OP_QUAD_WORD) ? `SFR_DUMMY_WORD :
                                                    `SFR_DUMMY_QUAD; // [RULE_18]
        end
        default: dclk_r <= 5'h00;                        // [RULE_02]
      endcase
    end
  endtask

  // Opcode is a read this engine serves
  function is_read;
    input [7:0] op;
    begin
      is_read = (op == `SFR_OP_READ) || (op == `SFR_OP_FAST) ||
                (op == `SFR_OP_DUAL_OUT) || (op == `SFR_OP_QUAD_OUT) ||
                (op == `SFR_OP_DUAL_IO) || (op == `SFR_OP_QUAD_IO) ||
                (op == `SFR_OP_QUAD_WORD);
    end
  endfunction

  // Quad I/O reads need the quad path
  function needs_quad;
    input [7:0] op;
    begin
      needs_quad = (op == `SFR_OP_QUAD_IO) || (op == `SFR_OP_QUAD_WORD);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Serial protocol engine
  // --------------------------------------------------------------------------
  // Runs off detected sclk edges; select high wins over everything but reset
  always @(posedge clk) begin
    if (rst) begin
      st_r       <= ST_IDLE;
      cnt_r      <= 5'h00;
      sh_r       <= 32'h00000000;
      op_r       <= 8'h00;
      rep_op_r   <= 8'h00;
      skip_r     <= 1'b0;
      ilw_r      <= 3'h1;
      dlw_r      <= 3'h1;
      mclk_r     <= 5'h00;
      dclk_r     <= 5'h00;
      wrap_use_r <= 1'b0;
      wrap_r     <= `SFR_WRAP_RST;                       // [RULE_20]
      addr_r     <= 24'h000000;
      osh_r      <= 8'h00;
      bcnt_r     <= 3'h0;
      io_out_r   <= 4'h0;
      io_oe_r    <= 4'h0;
    end else if (cs_high) begin
      st_r    <= ST_IDLE;                                // [RULE_23]
      io_oe_r <= 4'h0;
      ilw_r   <= 3'h1;
    end else begin
      case (st_r)
        ST_IDLE: begin
          // Repeat mode goes straight to the address phase
          if (skip_r) begin
            if (array_busy || (needs_quad(rep_op_r) && !qpe_r))
              st_r <= ST_SKIP;                           // [RULE_04]
            else
              start_read(rep_op_r);                      // [RULE_09] [RULE_14] [RULE_19]
          end else begin
            st_r  <= ST_CMD;
            cnt_r <= `SFR_CMD_CLKS;
          end
        end
        ST_CMD: begin
          if (sclk_rise) begin
            sh_r  <= {sh_r[30:0], io_s_r[0]};            // [RULE_23]
            cnt_r <= cnt_r - 5'h01;
            if (last_clk) begin
              if (cmd_nxt == `SFR_OP_SET_WRAP) begin
                st_r  <= ST_DUMMY;
                ilw_r <= 3'h4;                           // [RULE_16]
                op_r  <= cmd_nxt;
                cnt_r <= `SFR_WRAP_CLKS;
              end else if (cmd_nxt == `SFR_OP_MODE_RST) begin
                skip_r <= 1'b0;                          // [RULE_11]
                st_r   <= ST_SKIP;
              end else if (!is_read(cmd_nxt) || array_busy) begin
                st_r <= ST_SKIP;                         // [RULE_04]
              end else if (needs_quad(cmd_nxt) && !qpe_r) begin
                st_r <= ST_SKIP;                         // [RULE_13]
              end else begin
                start_read(cmd_nxt);
              end
            end
          end
        end
        ST_ADDR: begin
          if (sclk_rise) begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_r - 5'h01;
            if (last_clk) begin
              addr_r <= sh_nxt[23:0];                    // [RULE_01]
              if (mclk_r != 5'h00) begin
                st_r  <= ST_MODE;
                cnt_r <= mclk_r;
              end else if (dclk_r != 5'h00) begin
                st_r  <= ST_DUMMY;
                cnt_r <= dclk_r;
              end else begin
                st_r    <= ST_DATA;                      // [RULE_24]
                bcnt_r  <= 3'h0;
                io_oe_r <= lane_out(8'hFF, dlw_r);
              end
            end
          end
        end
        ST_MODE: begin
          if (sclk_rise) begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_r - 5'h01;
            if (last_clk) begin
              // Skip code 10 arms repeat mode, anything else leaves it
              skip_r   <= (sh_nxt[5:4] == `SFR_SKIP_CODE); // [RULE_09] [RULE_10]
              rep_op_r <= op_r;                          // [RULE_14] [RULE_19]
              if (dclk_r != 5'h00) begin
                st_r  <= ST_DUMMY;
                cnt_r <= dclk_r;
              end else begin
                st_r    <= ST_DATA;                      // [RULE_24]
                bcnt_r  <= 3'h0;
                io_oe_r <= lane_out(8'hFF, dlw_r);
              end
            end
          end
        end
        ST_DUMMY: begin
          // Also collects the 77H payload; the wrap byte arrives last
          if (sclk_rise) begin
            sh_r  <= sh_nxt;
            cnt_r <= cnt_r - 5'h01;
            if (last_clk) begin
              if (op_r == `SFR_OP_SET_WRAP) begin
                wrap_r <= sh_nxt[6:4];                   // [RULE_17] [RULE_20]
                st_r   <= ST_SKIP;
              end else begin
                st_r    <= ST_DATA;                      // [RULE_24]
                bcnt_r  <= 3'h0;
                io_oe_r <= lane_out(8'hFF, dlw_r);
              end
            end
          end
        end
        ST_DATA: begin
          // Memory word is ready long before the first falling edge
          if (sclk_fall) begin
            if (bcnt_r == 3'h0) begin
              io_out_r <= lane_out(mem_data, dlw_r);     // [RULE_02] [RULE_22]
              osh_r    <= lane_shl(mem_data, dlw_r);
              bcnt_r   <= (dlw_r == 3'h4) ? 3'h1 : (dlw_r == 3'h2) ? 3'h3 : 3'h7;
              addr_r   <= next_addr(addr_r,
                                    wrap_use_r & ~wrap_r[`SFR_WRAP_DIS_BIT],
                                    wrap_r[2:1]);        // [RULE_03] [RULE_15]
            end else begin
              io_out_r <= lane_out(osh_r, dlw_r);        // [RULE_06] [RULE_07]
              osh_r    <= lane_shl(osh_r, dlw_r);
              bcnt_r   <= bcnt_r - 3'h1;
            end
          end
        end
        ST_SKIP: begin
          io_oe_r <= 4'h0;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  // One wait state; write lands on the edge where the master sees ack
  always @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      qpe_r <= `SFR_CTRL_RST;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      if (wb_cyc_i && wb_stb_i && wb_we_i && ack_r &&
          (wb_adr_i == `SFR_REG_CTRL) && wb_sel_i[1])
        qpe_r <= wb_dat_i[`SFR_CTRL_QPE_BIT];            // [RULE_13]
      if (wb_cyc_i && wb_stb_i && !ack_r) begin
        case (wb_adr_i)
          `SFR_REG_CTRL: dat_r <= {22'h000000, qpe_r, 9'h000};
          `SFR_REG_STAT: dat_r <= {16'h0000, op_r, 1'b0, wrap_r, 1'b0,
                                   array_busy, ~cs_high, skip_r};
          `SFR_REG_ADDR: dat_r <= {8'h00, addr_r};
          default:       dat_r <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// >>> dv/sfr_read_engine_asserts.sv
// Port checker for the serial flash read engine, bound to its top module
`timescale 1ns/1ps
module sfr_chk (
  input wire        clk,
  input wire        rst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        spi_cs_n,
  input wire [3:0]  spi_io_oe,
  input wire        array_busy,
  input wire [23:0] mem_addr
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg busy_frame_r;
  // High while every cycle of this frame saw the array busy
  always @(posedge clk) begin
    if (rst) begin
      busy_frame_r <= 1'b0;
    end else begin
      busy_frame_r <= spi_cs_n ? 1'b1 : (busy_frame_r & array_busy);
    end
  end
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dat_hold;
    !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved while idle");
  property p_oe_cs;
    spi_cs_n [*6] |-> spi_io_oe == 4'h0;
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("lanes driven while deselected");
  property p_oe_code;
    spi_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF};
  endproperty
  a_oe_code: assert property (p_oe_code) else $error("bad lane set");
  property p_oe_hold;
    $past(spi_io_oe) != 4'h0 && spi_io_oe != 4'h0 |-> spi_io_oe == $past(spi_io_oe);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("lane set changed mid data");
  // Inside a burst the address only steps up or wraps inside its section
  property p_addr_step;
    spi_io_oe != 4'h0 && $past(spi_io_oe, 4) != 4'h0 && mem_addr != $past(mem_addr)
      |-> mem_addr == $past(mem_addr) + 24'h1 || (mem_addr >> 6) == ($past(mem_addr) >> 6);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address jump");
  property p_busy;
    busy_frame_r && !spi_cs_n |-> spi_io_oe == 4'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("read served while busy");
  c_ack: cover property (wb_ack_o);
  c_dual: cover property (spi_io_oe == 4'h3);
  c_quad: cover property (spi_io_oe == 4'hF);
endmodule

bind sfr_read_engine sfr_chk u_chk (
  .clk        (clk),
  .rst        (rst),
  .wb_cyc_i   (wb_cyc_i),
  .wb_stb_i   (wb_stb_i),
  .wb_ack_o   (wb_ack_o),
  .wb_dat_o   (wb_dat_o),
  .spi_cs_n   (spi_cs_n),
  .spi_io_oe  (spi_io_oe),
  .array_busy (array_busy),
  .mem_addr   (mem_addr)
);

// >>> dv/sfr_host.sv
// Host SPI controller model: mode 0 clock, select and data lanes
`timescale 1ns/1ps
module sfr_host (
  input  wire logic       clk,
  input  wire logic [3:0] io,
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      drv,
  output logic [3:0]      oe
);
  // Clock stands low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 4'h0;
    oe = 4'h0;
  end
  // One serial clock of 8 system clocks; sampled late so slow data settles
  task automatic cyc(input logic [3:0] d, input logic [3:0] e, output logic [3:0] q);
    sclk <= 1'b0;
    drv <= d;
    oe <= e;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (4) @(posedge clk);
    q = io;
  endtask
  task automatic xfer(input int w, input logic [7:0] b);
    logic [3:0] q;
    for (int i = 8 - w; i >= 0; i -= w) begin
      cyc(4'(b >> i) & 4'((1 << w) - 1), 4'((1 << w) - 1), q);
    end
  endtask
  // Dummy clocks keep the lanes driven low
  task automatic dmy(input int w, input int n);
    logic [3:0] q;
    for (int i = 0; i < n; i++) begin
      cyc(4'h0, 4'((1 << w) - 1), q);
    end
  endtask
  task automatic rcv(input int w, output logic [7:0] b);
    logic [3:0] q;
    b = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      cyc(4'h0, 4'h0, q);
      b = (b << w) | 8'((w == 1) ? {3'h0, q[1]} : q & 4'((1 << w) - 1));
    end
  endtask
  task automatic sel();
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Long idle between frames lets the device see select high
  task automatic desel();
    sclk <= 1'b0;
    oe <= 4'h0;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
endmodule

// >>> dv/tb.sv
// Self-checking bench: register access and host read commands
`timescale 1ns/1ps
`include "sfr_defs.vh"
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        busy = 1'b0;
  logic [7:0]  mdat = 8'h00;
  wire  [31:0] rdat;
  wire         ack;
  wire         sclk;
  wire         cs_n;
  wire  [3:0]  d_out;
  wire  [3:0]  d_oe;
  wire  [3:0]  h_drv;
  wire  [3:0]  h_oe;
  wire  [3:0]  io;
  wire  [23:0] maddr;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [7:0]  ops [4] = '{`SFR_OP_READ, `SFR_OP_FAST, `SFR_OP_DUAL_OUT, `SFR_OP_QUAD_OUT};
  int          wds [4] = '{1, 1, 2, 4};
  int          nds [4] = '{0, 8, 8, 8};
  function automatic logic [7:0] exp_b(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  // Board pull-ups lift any lane nobody drives
  assign io = (d_oe & d_out) | (~d_oe & h_oe & h_drv) | (~d_oe & ~h_oe);
  always #10 clk = ~clk;
  // Array model with one cycle of read latency
  always @(posedge clk) mdat <= exp_b(maddr);
  sfr_read_engine DUT (
    .clk        (clk),
    .rst        (rst),
    .wb_cyc_i   (cyc),
    .wb_stb_i   (stb),
    .wb_we_i    (we),
    .wb_adr_i   (adr),
    .wb_sel_i   (sel),
    .wb_dat_i   (wdat),
    .wb_dat_o   (rdat),
    .wb_ack_o   (ack),
    .spi_sclk   (sclk),
    .spi_cs_n   (cs_n),
    .spi_io_in  (io),
    .spi_io_out (d_out),
    .spi_io_oe  (d_oe),
    .array_busy (busy),
    .mem_addr   (maddr),
    .mem_data   (mdat)
  );
  sfr_host h (.clk(clk), .io(io), .sclk(sclk), .cs_n(cs_n), .drv(h_drv), .oe(h_oe));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h expected %h", $time, s, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One classic cycle; read data is taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && t < 50) begin
      @(posedge clk);
      t++;
    end
    if (t == 50) chk(32'h0, 32'h1, "no ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Whole read frame; op 0 skips the opcode, wm marks the wrapping address bits
  task automatic rdx(input logic [7:0] op, input int wa, input int wd, input int nd,
                     input logic hm, input logic [7:0] m, input logic [23:0] a,
                     input logic [23:0] wm, input int n, input logic ok);
    logic [7:0]  b;
    logic [23:0] p;
    p = a;
    h.sel();
    if (op != 8'h00) h.xfer(1, op);
    h.xfer(wa, a[23:16]);
    h.xfer(wa, a[15:8]);
    h.xfer(wa, a[7:0]);
    if (hm) h.xfer(wa, m);
    h.dmy(wa, nd);
    for (int i = 0; i < n; i++) begin
      h.rcv(wd, b);
      chk({24'h0, b}, ok ? {24'h0, exp_b(p)} : 32'hFF, "read byte");
      p = (p & ~wm) | ((p + 24'h1) & wm);
    end
    h.desel();
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    $display("[ERR] %0t watchdog expired", $time);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b0, `SFR_REG_CTRL, 32'h0);
    chk(q, 32'h0, "ctrl reset");
    wb(1'b0, `SFR_REG_STAT, 32'h0);
    chk(q & 32'h77, 32'h70, "stat reset");
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0, "unmapped");
    $display("end of test: registers");
    for (int k = 0; k < 4; k++) begin
      rdx(ops[k], 1, wds[k], nds[k], 1'b0, 8'h00, 24'h0000FE, 24'hFFFFFF, 3, 1'b1);
    end
    busy <= 1'b1;
    rdx(`SFR_OP_READ, 1, 1, 0, 1'b0, 8'h00, 24'h000010, 24'hFFFFFF, 2, 1'b0);
    busy <= 1'b0;
    rdx(`SFR_OP_QUAD_IO, 4, 4, 4, 1'b1, 8'h00, 24'h000040, 24'hFFFFFF, 2, 1'b0);
    $display("end of test: single and refused reads");
    wb(1'b1, `SFR_REG_CTRL, 32'h200);
    wb(1'b0, `SFR_REG_CTRL, 32'h0);
    chk(q, 32'h200, "quad enable");
    h.sel();
    h.xfer(1, `SFR_OP_SET_WRAP);
    for (int k = 0; k < 4; k++) begin
      h.xfer(4, 8'h00);
    end
    h.desel();
    wb(1'b0, `SFR_REG_STAT, 32'h0);
    chk(q & 32'h70, 32'h0, "wrap set");
    rdx(`SFR_OP_QUAD_IO, 4, 4, 4, 1'b1, 8'h20, 24'h000106, 24'h7, 4, 1'b1);
    wb(1'b0, `SFR_REG_STAT, 32'h0);
    chk(q & 32'h1, 32'h1, "armed");
    h.sel();
    h.xfer(1, `SFR_OP_MODE_RST);
    h.desel();
    wb(1'b0, `SFR_REG_STAT, 32'h0);
    chk(q & 32'h1, 32'h0, "disarmed");
    rdx(`SFR_OP_QUAD_WORD, 4, 4, 2, 1'b1, 8'h20, 24'h0001FE, 24'h7, 3, 1'b1);
    // Armed word read repeats with no opcode; mode 00 here disarms it again
    rdx(8'h00, 4, 4, 2, 1'b1, 8'h00, 24'h0001F0, 24'h7, 2, 1'b1);
    $display("end of test: quad and wrap");
    rdx(`SFR_OP_DUAL_IO, 2, 2, 0, 1'b1, 8'h20, 24'h002345, 24'hFFFFFF, 2, 1'b1);
    rdx(8'h00, 2, 2, 0, 1'b1, 8'h00, 24'h003000, 24'hFFFFFF, 2, 1'b1);
    wb(1'b0, `SFR_REG_STAT, 32'h0);
    chk(q & 32'h1, 32'h0, "repeat left");
    rdx(`SFR_OP_READ, 1, 1, 0, 1'b0, 8'h00, 24'h000500, 24'hFFFFFF, 1, 1'b1);
    // One byte read plus the closing clock fall of the frame, which starts one more byte
    wb(1'b0, `SFR_REG_ADDR, 32'h0);
    chk(q, 32'h502, "next address");
    $display("end of test: repeat mode");
    stop_test();
  end
endmodule
